// ---- verification/pulse_timer_slaves_tb.sv ----
// Purpose: Self-checking bench for timers 2 to 4 and their register port.
// Assumes: BASE_CYCLES is 4, so a 4 ms period is 160 clock cycles.
// Notes: Pulse widths are counted on falling edges, after outputs settle.
`default_nettype none
`timescale 1ns/10ps
module pulse_timer_slaves_tb;
	localparam int BC = 4;
	logic clk_in = 1'b0, rst_in = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic t1s = 1'b0, t1e = 1'b0;
	logic [7:0] d2 = 8'h00, d3 = 8'h00, d4 = 8'h00;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic timer2, timer3, timer4;
	int fails = 0, checks = 0;
	pulse_timer_slaves #(.BASE_CYCLES(BC)) i_pulse_timer_slaves (
		.clk_in(clk_in), .rst_in(rst_in),
		.awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
		.wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
		.wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
		.bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
		.arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
		.rvalid_out(rvalid), .rready_in(rready),
		.t1_pulse_start_in(t1s), .t1_pulse_end_in(t1e),
		.timer2_duty_value_in(d2), .timer3_duty_value_in(d3),
		.timer4_duty_value_in(d4), .timer2_pulse_out(timer2),
		.timer3_pulse_out(timer3), .timer4_pulse_out(timer4)
	);
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	function automatic logic [11:0] adr(input logic [9:0] idx);
		adr = {idx, 2'b00};
	endfunction : adr
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] exp);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge clk_in);
		awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF;
		wvalid <= 1'b1; bready <= 1'b1;
		while (!done) begin
			@(posedge clk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				check("write response", 32'(bresp), 32'(exp));
				bready <= 1'b0;
				done = 1'b1;
			end
			if (++n > 50) begin
				fails++;
				tally_and_finish();
			end
		end
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge clk_in);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!done) begin
			@(posedge clk_in);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				check("read data", rdata, exp);
				check("read response", 32'(rresp), 32'(er));
				rready <= 1'b0;
				done = 1'b1;
			end
			if (++n > 50) begin
				fails++;
				tally_and_finish();
			end
		end
	endtask : rd
	task automatic trig(input logic s, input logic e);
		@(posedge clk_in);
		t1s <= s; t1e <= e;
		@(posedge clk_in);
		t1s <= 1'b0; t1e <= 1'b0;
	endtask : trig
	task automatic count(input int n, output int c2, c3, c4, ov);
		c2 = 0; c3 = 0; c4 = 0; ov = 0;
		repeat (n) begin
			@(negedge clk_in);
			c2 += int'(timer2 === 1'b1);
			c3 += int'(timer3 === 1'b1);
			c4 += int'(timer4 === 1'b1);
			ov += int'(timer3 === 1'b1 && timer4 === 1'b1);
		end
	endtask : count
	task automatic regs_test();
		rd(adr(pulse_timer_pkg::IDX_T3_CTRL), 32'h0, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T3_CTRL), 32'hFF, 2'h0);
		rd(adr(pulse_timer_pkg::IDX_T3_CTRL), 32'h3F, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T4_CTRL), 32'h1D, 2'h0);
		rd(adr(pulse_timer_pkg::IDX_T4_CTRL), 32'h1D, 2'h0);
		d2 <= 8'hA5; d3 <= 8'h5A; d4 <= 8'hFF;
		wr(adr(pulse_timer_pkg::IDX_T2_DUTY), 32'h11, 2'h0);
		rd(adr(pulse_timer_pkg::IDX_T2_DUTY), 32'hA5, 2'h0);
		rd(adr(pulse_timer_pkg::IDX_T3_DUTY), 32'h5A, 2'h0);
		rd(adr(pulse_timer_pkg::IDX_T4_DUTY), 32'hFF, 2'h0);
		wr(12'h000, 32'h3, 2'h2);
		rd(12'h000, 32'h0, 2'h2);
	endtask : regs_test
	task automatic periodic_test();
		int c2, c3, c4, ov;
		d2 <= 8'd51; d3 <= 8'd5; d4 <= 8'd5;
		wr(adr(pulse_timer_pkg::IDX_T2_CTRL), 32'h00, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T3_CTRL), 32'h01, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T4_CTRL), 32'h05, 2'h0);
		count(80 * BC, c2, c3, c4, ov);
		check("pwm on cycles", 32'(c2), 32'(16 * BC));
		check("timed on cycles", 32'(c3), 32'(10 * BC));
		check("8 ms on cycles", 32'(c4), 32'(5 * BC));
	endtask : periodic_test
	task automatic slave_test();
		int c2, c3, c4, ov, bad;
		d2 <= 8'd0; d3 <= 8'd2; d4 <= 8'd3;
		wr(adr(pulse_timer_pkg::IDX_T2_CTRL), 32'h00, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T3_CTRL), 32'h3E, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T4_CTRL), 32'h06, 2'h0);
		count(20 * BC, c2, c3, c4, ov);
		check("timer3 idle", 32'(timer3), 32'h0);
		trig(1'b1, 1'b0);
		count(6 * BC, c2, c3, c4, ov);
		check("slave3 width", 32'(c3 >= 2 * BC && c3 <= 2 * BC + 1), 1);
		check("slave4 width", 32'(c4 >= 3 * BC && c4 <= 3 * BC + 1), 1);
		bad = 0;
		trig(1'b1, 1'b0);
		repeat (3) begin
			count(BC + 1, c2, c3, c4, ov);
			bad = int'(c3 != BC + 1) + bad;
			trig(1'b1, 1'b0);
		end
		check("retrigger holds on", 32'(bad), 32'h0);
		count(6 * BC, c2, c3, c4, ov);
	endtask : slave_test
	task automatic follow_test();
		int c2, c3, c4, ov;
		d2 <= 8'd0; d3 <= 8'd2; d4 <= 8'd1;
		wr(adr(pulse_timer_pkg::IDX_T2_CTRL), 32'h03, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T3_CTRL), 32'h03, 2'h0);
		wr(adr(pulse_timer_pkg::IDX_T4_CTRL), 32'h03, 2'h0);
		trig(1'b0, 1'b1);
		count(8 * BC, c2, c3, c4, ov);
		check("zero duty off", 32'(c2), 32'h0);
		check("follow3 width", 32'(c3 >= 2 * BC && c3 <= 2 * BC + 1), 1);
		check("follow4 width", 32'(c4 >= BC && c4 <= BC + 1), 1);
		check("follow overlap", 32'(ov), 32'h0);
	endtask : follow_test
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		regs_test();
		periodic_test();
		slave_test();
		follow_test();
		tally_and_finish();
	end
endmodule : pulse_timer_slaves_tb
`default_nettype wire

// ---- verilog/pulse_timer_pkg.sv ----
// Purpose: Shared constants and types for the slave pulse timer block.
// Assumes: 125 MHz clock, 100 us timer base, 32-bit register bus.
// Notes: Register indices are word indices; byte address is index times 4.
`default_nettype none
package pulse_timer_pkg;

	localparam int CLK_MHZ = 125;
	localparam int BASE_US = 100;
	localparam int BASE_CYCLES = BASE_US * CLK_MHZ;
	localparam int ADDR_W = 12;
	localparam int DUTY_DEN = 255;

	// Register indices, byte address = index * 4.
	localparam logic [9:0] IDX_T2_CTRL = 10'h052;
	localparam logic [9:0] IDX_T2_DUTY = 10'h053;
	localparam logic [9:0] IDX_T3_CTRL = 10'h054;
	localparam logic [9:0] IDX_T3_DUTY = 10'h055;
	localparam logic [9:0] IDX_T4_CTRL = 10'h056;
	localparam logic [9:0] IDX_T4_DUTY = 10'h057;

	// Control field layout.
	localparam int MODE_LSB = 0;
	localparam int PERIOD_LSB = 2;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [7:0] DUTY_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Periods counted in base ticks.
	localparam logic [15:0] TICKS_4MS = 16'(4 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_8MS = 16'(8 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_20MS = 16'(20 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_30MS = 16'(30 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_50MS = 16'(50 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_100MS = 16'(100 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_200MS = 16'(200 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_400MS = 16'(400 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_800MS = 16'(800 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_1S = 16'(1000 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_2S = 16'(2000 * 1000 / BASE_US);
	localparam logic [15:0] TICKS_4S = 16'(4000 * 1000 / BASE_US);

	typedef enum logic [1:0] {
		MODE_PWM,
		MODE_TIMED,
		MODE_SLAVE,
		MODE_FOLLOW
	} mode_e;

	function automatic logic [15:0] period_ticks(input logic [3:0] sel);
		case (sel)
			4'h0: period_ticks = TICKS_4MS;
			4'h1: period_ticks = TICKS_8MS;
			4'h2: period_ticks = TICKS_20MS;
			4'h3: period_ticks = TICKS_30MS;
			4'h4: period_ticks = TICKS_50MS;
			4'h5: period_ticks = TICKS_100MS;
			4'h6: period_ticks = TICKS_200MS;
			4'h7: period_ticks = TICKS_400MS;
			4'h8: period_ticks = TICKS_800MS;
			4'h9: period_ticks = TICKS_1S;
			4'hA: period_ticks = TICKS_2S;
			default: period_ticks = TICKS_4S;
		endcase
	endfunction : period_ticks

endpackage : pulse_timer_pkg
`default_nettype wire

// ---- verilog/pulse_timer_slaves.sv ----
// Purpose: Timers 2 to 4 of a four-timer unit with an AXI4-Lite slave.
// Assumes: Timer 1 start and end pulses come from logic on this clock.
// Notes: Duty registers are read-only and load from the duty inputs.
//
// Behaviour
// - Period select bits 5:2 choose 4 ms up to 4 s, twelve codes.
// - Mode 00 is PWM; on-time is duty times period over 255.
// - Mode 01 gives on-time duty times base time, repeating at period.
// - Mode 10 starts timer 3 pulse at timer 1 pulse start.
// - Mode 11 starts timer 3 pulse when timer 2 pulse ends.
// - Mode 10 starts timer 4 pulse with timer 1 pulse start.
// - Mode 11 starts timer 4 pulse at end of timer 3 pulse.
// - Duty register holds eight bits; duty fraction is value over 255.
// - Control bits 7:6 read-only; period and mode fields read-write.
// - Slave and follower pulses count 100 us steps, ignoring period.
// - A slave pulse longer than inherited period keeps output on.
// - Slave and follower still trigger when timer 1 duty is zero.
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
`timescale 1ns/10ps
module pulse_timer_slaves #(
	parameter int BASE_CYCLES = pulse_timer_pkg::BASE_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [pulse_timer_pkg::ADDR_W-1:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [pulse_timer_pkg::ADDR_W-1:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	input wire logic t1_pulse_start_in,
	input wire logic t1_pulse_end_in,
	input wire logic [7:0] timer2_duty_value_in,
	input wire logic [7:0] timer3_duty_value_in,
	input wire logic [7:0] timer4_duty_value_in,
	output logic timer2_pulse_out,
	output logic timer3_pulse_out,
	output logic timer4_pulse_out
);

	localparam int AW = pulse_timer_pkg::ADDR_W;

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rd_ctrl;
		logic [2:0][5:0] ctrl;
		logic [2:0][7:0] duty;
	} top_s;

	top_s top_reg;
	top_s top_next;
	logic [9:0] widx;
	logic [9:0] ridx;
	logic [2:0][7:0] duty_in;
	logic [2:0] pulse;
	logic [2:0] pulse_end;

	assign widx = top_reg.awaddr[AW-1:2];
	assign ridx = araddr_in[AW-1:2];
	assign duty_in[0] = timer2_duty_value_in;
	assign duty_in[1] = timer3_duty_value_in;
	assign duty_in[2] = timer4_duty_value_in;

	always_comb begin
		top_next = top_reg;
		top_next.duty = duty_in;
		// Write address and data are taken in either order.
		if (awvalid_in && top_reg.awready) begin
			top_next.aw_have = 1'b1;
			top_next.awaddr = awaddr_in;
		end
		if (wvalid_in && top_reg.wready) begin
			top_next.w_have = 1'b1;
			top_next.wdata = wdata_in;
			top_next.wstrb = wstrb_in;
		end
		if (top_reg.bvalid && bready_in) begin
			top_next.bvalid = 1'b0;
		end
		if (top_reg.aw_have && top_reg.w_have && !top_reg.bvalid) begin
			top_next.aw_have = 1'b0;
			top_next.w_have = 1'b0;
			top_next.bvalid = 1'b1;
			top_next.bresp = pulse_timer_pkg::RESP_SLVERR;
			for (int i = 0; i < 3; i++) begin
				if (widx == pulse_timer_pkg::IDX_T2_CTRL + 10'(2 * i)) begin
					top_next.bresp = pulse_timer_pkg::RESP_OKAY;
					if (top_reg.wstrb[0]) begin
						top_next.ctrl[i] = top_reg.wdata[5:0];
					end
				end
				// Duty registers are read-only; writes are dropped.
				if (widx == pulse_timer_pkg::IDX_T2_DUTY + 10'(2 * i)) begin
					top_next.bresp = pulse_timer_pkg::RESP_OKAY;
				end
			end
		end
		top_next.awready = !top_next.aw_have && !top_next.bvalid;
		top_next.wready = !top_next.w_have && !top_next.bvalid;

		if (top_reg.rvalid && rready_in) begin
			top_next.rvalid = 1'b0;
		end
		if (arvalid_in && top_reg.arready) begin
			top_next.rvalid = 1'b1;
			top_next.rdata = 32'h00000000;
			top_next.rresp = pulse_timer_pkg::RESP_SLVERR;
			top_next.rd_ctrl = 1'b0;
			for (int i = 0; i < 3; i++) begin
				if (ridx == pulse_timer_pkg::IDX_T2_CTRL + 10'(2 * i)) begin
					top_next.rresp = pulse_timer_pkg::RESP_OKAY;
					top_next.rd_ctrl = 1'b1;
					top_next.rdata = {26'h0000000, top_reg.ctrl[i]};
				end
				if (ridx == pulse_timer_pkg::IDX_T2_DUTY + 10'(2 * i)) begin
					top_next.rresp = pulse_timer_pkg::RESP_OKAY;
					top_next.rdata = {24'h000000, top_reg.duty[i]};
				end
			end
		end
		top_next.arready = !top_next.rvalid;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			top_reg <= '0;
			top_reg.ctrl <= {3{pulse_timer_pkg::CTRL_RESET}};
			top_reg.duty <= {3{pulse_timer_pkg::DUTY_RESET}};
		end else begin
			top_reg <= top_next;
		end
	end

	assign awready_out = top_reg.awready;
	assign wready_out = top_reg.wready;
	assign bvalid_out = top_reg.bvalid;
	assign bresp_out = top_reg.bresp;
	assign arready_out = top_reg.arready;
	assign rvalid_out = top_reg.rvalid;
	assign rdata_out = top_reg.rdata;
	assign rresp_out = top_reg.rresp;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_chan
			logic follow_trig;
			// Timer 2 follows timer 1; each later timer follows the one before.
			if (g == 0) begin : gen_first
				assign follow_trig = t1_pulse_end_in;
			end else begin : gen_rest
				assign follow_trig = pulse_end[g-1];
			end
			timer_channel #(
				.BASE_CYCLES(BASE_CYCLES)
			) u_chan (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.mode_in(top_reg.ctrl[g][pulse_timer_pkg::MODE_LSB +: 2]),
				.period_select_in(top_reg.ctrl[g][pulse_timer_pkg::PERIOD_LSB +: 4]),
				.duty_in(top_reg.duty[g]),
				.start_trig_in(t1_pulse_start_in),
				.follow_trig_in(follow_trig),
				.pulse_out(pulse[g]),
				.end_out(pulse_end[g])
			);
		end
	endgenerate

	assign timer2_pulse_out = pulse[0];
	assign timer3_pulse_out = pulse[1];
	assign timer4_pulse_out = pulse[2];

	a_resv_read_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		(rvalid_out && top_reg.rd_ctrl) |-> (rdata_out[31:6] == 26'h0000000))
		else $error("reserved control bits read non-zero");
	a_ctrl_write_takes: assert property (@(posedge clk_in) disable iff (rst_in)
		(top_reg.aw_have && top_reg.w_have && !top_reg.bvalid &&
		widx == 10'h054 && top_reg.wstrb[0])
		|=> (top_reg.ctrl[1] == $past(top_reg.wdata[5:0]) && bvalid_out))
		else $error("control write not stored");
	a_duty_tracks: assert property (@(posedge clk_in) disable iff (rst_in)
		##1 (top_reg.duty[2] == $past(timer4_duty_value_in)))
		else $error("duty register does not follow its input");
	a_read_answer: assert property (@(posedge clk_in) disable iff (rst_in)
		(arvalid_in && arready_out) |=> (rvalid_out && !arready_out))
		else $error("read not answered in one cycle");
	a_resp_holds: assert property (@(posedge clk_in) disable iff (rst_in)
		(bvalid_out && !bready_in) |=> (bvalid_out && $stable(bresp_out)))
		else $error("write response dropped before taken");

endmodule : pulse_timer_slaves
`default_nettype wire

// ---- verilog/timer_channel.sv ----
// Purpose: One PWM / pulse timer channel with slave and follower triggers.
// Assumes: Trigger inputs are one-cycle pulses on the same clock.
// Notes: end_out pulses when the pulse ends, or at a trigger with zero duty.
`default_nettype none
`timescale 1ns/10ps
module timer_channel #(
	parameter int BASE_CYCLES = pulse_timer_pkg::BASE_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] mode_in,
	input wire logic [3:0] period_select_in,
	input wire logic [7:0] duty_in,
	input wire logic start_trig_in,
	input wire logic follow_trig_in,
	output logic pulse_out,
	output logic end_out
);

	localparam int PRE_W = $clog2(BASE_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(BASE_CYCLES - 1);

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [15:0] cnt;
		logic run;
		logic out;
		logic end_p;
	} chan_s;

	chan_s chan_reg;
	chan_s chan_next;
	logic tick;
	logic trig;
	logic on;
	logic [15:0] period;
	logic [15:0] cnt_inc;
	logic [23:0] lhs;
	logic [23:0] rhs;

	assign tick = chan_reg.pre == PRE_LAST;
	assign period = pulse_timer_pkg::period_ticks(period_select_in);
	assign cnt_inc = chan_reg.cnt + 16'h0001;
	// PWM compares cnt*255 against duty*period instead of dividing.
	assign lhs = 24'(chan_reg.cnt) * 24'(pulse_timer_pkg::DUTY_DEN);
	assign rhs = 24'(duty_in) * 24'(period);
	assign trig = (mode_in == 2'(pulse_timer_pkg::MODE_SLAVE)) ? start_trig_in
		: follow_trig_in;

	always_comb begin
		chan_next = chan_reg;
		chan_next.end_p = 1'b0;
		on = 1'b0;
		chan_next.pre = tick ? '0 : chan_reg.pre + PRE_W'(1);
		if (mode_in[1] == 1'b0) begin
			if (tick) begin
				chan_next.cnt = (cnt_inc >= period) ? 16'h0000 : cnt_inc;
			end
			if (mode_in == 2'(pulse_timer_pkg::MODE_PWM)) begin
				on = lhs < rhs;
			end else begin
				on = chan_reg.cnt < 16'(duty_in);
			end
			chan_next.run = 1'b0;
			chan_next.out = on;
			chan_next.end_p = chan_reg.out & ~on;
		end else begin
			// Period select is ignored here; the trigger sets the period.
			if (trig) begin
				chan_next.pre = '0;
				chan_next.cnt = 16'h0000;
				// A retrigger with non-zero duty while running keeps the output on.
				chan_next.run = duty_in != 8'h00;
				chan_next.end_p = duty_in == 8'h00;
			end else if (chan_reg.run && tick) begin
				chan_next.cnt = cnt_inc;
				if (cnt_inc >= 16'(duty_in)) begin
					chan_next.run = 1'b0;
					chan_next.end_p = 1'b1;
				end
			end
			chan_next.out = chan_next.run;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			chan_reg <= '0;
		end else begin
			chan_reg <= chan_next;
		end
	end

	assign pulse_out = chan_reg.out;
	assign end_out = chan_reg.end_p;

	a_slave_start: assert property (@(posedge clk_in) disable iff (rst_in)
		(mode_in == 2'h2 && start_trig_in && duty_in != 8'h00) |=> pulse_out)
		else $error("slave pulse did not start on master start");
	a_follow_start: assert property (@(posedge clk_in) disable iff (rst_in)
		(mode_in == 2'h3 && follow_trig_in && duty_in != 8'h00) |=> pulse_out)
		else $error("follower pulse did not start on previous end");
	a_zero_duty_end: assert property (@(posedge clk_in) disable iff (rst_in)
		(mode_in[1] && trig && duty_in == 8'h00) |=> (end_out && !pulse_out))
		else $error("zero duty trigger not passed on");
	a_retrigger_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		(mode_in[1] && pulse_out && trig && duty_in != 8'h00) |=> pulse_out)
		else $error("retriggered slave dropped its output");
	a_long_code: assert property (@(posedge clk_in) disable iff (rst_in)
		(period_select_in >= 4'hC) |-> (period == 16'd40000))
		else $error("unlisted period code not mapped to 4 s");
	a_pwm_zero_off: assert property (@(posedge clk_in) disable iff (rst_in)
		(mode_in == 2'h0 && duty_in == 8'h00) [*2] |-> !pulse_out)
		else $error("pwm output on at zero duty");

endmodule : timer_channel
`default_nettype wire
